// [src/scp_defs.svh]
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// ==========================================================================
// Register offsets in the control block
`define SCP_OFS_PART_HIGH    8'h00
`define SCP_OFS_PART_MID     8'h01
`define SCP_OFS_PART_LOW     8'h02
`define SCP_OFS_REVISION     8'h03
`define SCP_OFS_FIRST_RW     8'h04
`define SCP_OFS_LAST_RW      8'h09
`define SCP_NUM_RW           6
// Highest pointer value; control block auto increment stops here
`define SCP_PTR_MAX          8'h4c

// ==========================================================================
// Field positions in soft_reset_key_ramp_ctrl and keying_overlay_ctrl
`define SCP_SRST_BIT         3
`define SCP_DATA_KEY_ENABLE_BIT         2
`define SCP_RAMP_MSB         1
`define SCP_RAMP_LSB         0
`define SCP_HARDWARE_KEY_ENABLE_BIT         7

// ==========================================================================
// Writable bit masks; reserved bits read back as zero
`define SCP_MASK_RESET_CTRL  8'h0f
`define SCP_MASK_INPUT_FMT   8'hbf
`define SCP_MASK_GENERAL     8'hff
`define SCP_MASK_ANC_CTRL    8'he7
`define SCP_MASK_ANC_IDENT   8'hff
`define SCP_MASK_KEYING      8'hff

// ==========================================================================
// Reset value of every writable register; soft reset starts asserted
`define SCP_RW_RESET         8'h00

// ==========================================================================
// Serial protocol constants
`define SCP_ADDR_UPPER       5'b10101
`define SCP_BLOCK_CTRL       8'h00
`define SCP_BLOCK_OVERLAY_LOOKUP_TABLE       8'h01
`define SCP_OVERLAY_LOOKUP_TABLE_LAST_LANE   2'd2
`define SCP_ACK_SLOT         4'd8
`define SCP_LAST_DATA_BIT    4'd7

`endif

// [src/scp_pkg.sv]
`default_nettype none
package scp_pkg;
  // Serial port transaction phase
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_BLOCK,
    ST_OFFSET,
    ST_WRITE,
    ST_READ
  } scp_state_t;
endpackage
`default_nettype wire

// [src/scp_serial_port.sv]
// Functional notes
// - A read returns data from the base address of the last write; here a read starts from the pointer as auto increment left it.
// - Each sent byte advances the register address by one; here the control pointer holds at 4c.
// - Stop condition ends a write transaction.
// - Missing acknowledge from the master ends a read transaction.
// - Start without stop is a repeated start and begins a new address phase.
// - Write order is address, block pointer, offset pointer, data; block 00 is control.
// - Control writes go to consecutive addresses from the offset pointer.
// - Block 01 selects the overlay table at the offset location.
// - Table location holds luma, blue, red bytes; advance after the third.
// - Offsets 00 to 02 return fixed part code, 03 the revision.
// - Register 04 holds soft reset bit 3, key enable bit 2, ramp mode 1-0.
// - Acknowledge own address on the ninth clock; ignore other addresses.
// - Low two slave address bits come from the address select pins.
// - Soft reset low holds the video logic idle and its outputs disabled.
`include "scp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module scp_serial_port
  import scp_pkg::*;
#(
  parameter logic [7:0] PART_CODE_HIGH = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE_MID  = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_CODE_LOW  = 8'hc3, // Arbitrary value
  parameter logic [7:0] REVISION       = 8'h01, // Arbitrary value
  parameter int         OVERLAY_LOOKUP_TABLE_DEPTH     = 256
) (
  // Clocks and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        link_clk,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic [1:0]  address_select_pins,
  // Control outputs, mclk domain
  output logic             video_run_en,
  output logic             data_key_enable,
  output logic [1:0]       pixel_ramp_mode,
  output logic [7:0]       input_format_ctrl,
  output logic [7:0]       video_general_ctrl,
  output logic [7:0]       ancillary_lock_ctrl,
  output logic [7:0]       ancillary_ident_value,
  output logic [7:0]       keying_overlay_ctrl,
  output logic             hardware_key_enable,
  // Overlay table read port, mclk domain
  input  wire logic [7:0]  overlay_lookup_table_rd_addr,
  output logic [23:0]      overlay_lookup_table_rd_data
);

  // ========================================================================
  // Elaboration checks
  if (OVERLAY_LOOKUP_TABLE_DEPTH < 1 || OVERLAY_LOOKUP_TABLE_DEPTH > 256) begin : g_depth_chk
    $error("OVERLAY_LOOKUP_TABLE_DEPTH must lie in 1..256");
  end

  // ========================================================================
  // Decode helpers
  function automatic logic is_rw(input logic [7:0] ofs);
    return (ofs >= `SCP_OFS_FIRST_RW) && (ofs <= `SCP_OFS_LAST_RW);
  endfunction

  function automatic logic [7:0] rw_mask(input int idx);
    case (idx)
      0:       return `SCP_MASK_RESET_CTRL;
      1:       return `SCP_MASK_INPUT_FMT;
      2:       return `SCP_MASK_GENERAL;
      3:       return `SCP_MASK_ANC_CTRL;
      4:       return `SCP_MASK_ANC_IDENT;
      default: return `SCP_MASK_KEYING;
    endcase
  endfunction

  // ========================================================================
  // Link domain declarations
  logic             scl_s, sda_s, scl_d_ff, sda_d_ff;
  logic [1:0]       sel_s;
  scp_state_t       state_ff;
  logic [3:0]       bit_cnt_ff;
  logic [7:0]       rx_ff, tx_ff, block_ff, ptr_ff;
  logic [1:0]       lane_ff;
  logic             drive_low_ff, match_ff, rw_ff, master_ack_ff, upd_tog_ff;
  logic [7:0]       ctrl_ff [`SCP_NUM_RW];
  logic [23:0]      overlay_lookup_table_mem [OVERLAY_LOOKUP_TABLE_DEPTH];
  logic             scl_rise, scl_fall, start_det, stop_det, bus_evt;
  logic             byte_end, ack_end, addr_hit, wr_strobe, rd_load;
  logic [7:0]       rd_byte, nxt_ptr;
  logic [1:0]       nxt_lane;

  // ========================================================================
  // Pin synchronisers; bus lines idle high
  scp_sync #(.WIDTH(4), .RESET_VAL(4'hc)) u_pin_sync (
    .clk   (link_clk),
    .rst_n (resetn),
    .d     ({scl_i, sda_i, address_select_pins}),
    .q     ({scl_s, sda_s, sel_s})
  );

  // Previous line levels for edge detection
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // Bus events; start and stop are data edges with the clock high
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign bus_evt   = start_det | stop_det;
  assign byte_end  = scl_fall & ~bus_evt & (bit_cnt_ff == `SCP_LAST_DATA_BIT)
                     & (state_ff != ST_IDLE);
  assign ack_end   = scl_fall & ~bus_evt & (bit_cnt_ff == `SCP_ACK_SLOT)
                     & (state_ff != ST_IDLE);
  assign addr_hit  = (rx_ff[7:1] == {`SCP_ADDR_UPPER, sel_s});
  assign wr_strobe = byte_end & (state_ff == ST_WRITE);
  // Next byte is fetched as the ack slot closes, so data leaves on time
  assign rd_load   = ack_end & (((state_ff == ST_ADDR) & match_ff & rw_ff)
                     | ((state_ff == ST_READ) & master_ack_ff));

  // ========================================================================
  // Transaction phase and bit counter
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff      <= ST_IDLE;
      bit_cnt_ff    <= 4'd0;
      match_ff      <= 1'b0;
      rw_ff         <= 1'b0;
      master_ack_ff <= 1'b0;
    end else if (start_det) begin
      state_ff   <= ST_ADDR;
      // Armed one below zero: the start's own clock fall is not a data bit
      bit_cnt_ff <= 4'hf;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
    end else if (state_ff != ST_IDLE) begin
      if (scl_rise && bit_cnt_ff == `SCP_ACK_SLOT) begin
        master_ack_ff <= ~sda_s;
      end
      if (scl_fall) begin
        bit_cnt_ff <= (bit_cnt_ff == `SCP_ACK_SLOT) ? 4'd0 : 4'(bit_cnt_ff + 4'd1);
      end
      if (byte_end && state_ff == ST_ADDR) begin
        match_ff <= addr_hit;
        rw_ff    <= rx_ff[0];
        if (!addr_hit) begin
          state_ff <= ST_IDLE;
        end
      end
      if (ack_end) begin
        unique case (state_ff)
          ST_ADDR:   state_ff <= rw_ff ? ST_READ : ST_BLOCK;
          ST_BLOCK:  state_ff <= ST_OFFSET;
          ST_OFFSET: state_ff <= ST_WRITE;
          ST_READ:   state_ff <= master_ack_ff ? ST_READ : ST_IDLE;
          ST_WRITE:  state_ff <= ST_WRITE;
          ST_IDLE:   state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // Receive shifter, MSB first, sampled on the rising clock
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ff <= 8'h00;
    end else if (scl_rise && bit_cnt_ff < `SCP_ACK_SLOT && state_ff != ST_READ) begin
      rx_ff <= {rx_ff[6:0], sda_s};
    end
  end

  // ========================================================================
  // Block and offset pointers with auto increment
  always_comb begin
    nxt_ptr  = ptr_ff;
    nxt_lane = lane_ff;
    if (block_ff == `SCP_BLOCK_CTRL) begin
      if (ptr_ff != `SCP_PTR_MAX) begin
        nxt_ptr = 8'(ptr_ff + 8'd1);
      end
    end else if (block_ff == `SCP_BLOCK_OVERLAY_LOOKUP_TABLE) begin
      if (lane_ff == `SCP_OVERLAY_LOOKUP_TABLE_LAST_LANE) begin
        nxt_lane = 2'd0;
        nxt_ptr  = 8'(ptr_ff + 8'd1);
      end else begin
        nxt_lane = 2'(lane_ff + 2'd1);
      end
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      block_ff <= 8'h00;
      ptr_ff   <= 8'h00;
      lane_ff  <= 2'd0;
    end else if (byte_end && state_ff == ST_BLOCK) begin
      block_ff <= rx_ff;
    end else if (byte_end && state_ff == ST_OFFSET) begin
      ptr_ff  <= rx_ff;
      lane_ff <= 2'd0;
    end else if (wr_strobe || rd_load) begin
      // Pointer survives a stop, so a later read starts where the last write left it
      ptr_ff  <= nxt_ptr;
      lane_ff <= nxt_lane;
    end
  end

  // ========================================================================
  // Read data selection
  always_comb begin
    rd_byte = 8'h00;
    if (block_ff == `SCP_BLOCK_CTRL) begin
      unique case (ptr_ff)
        `SCP_OFS_PART_HIGH: rd_byte = PART_CODE_HIGH;
        `SCP_OFS_PART_MID:  rd_byte = PART_CODE_MID;
        `SCP_OFS_PART_LOW:  rd_byte = PART_CODE_LOW;
        `SCP_OFS_REVISION:  rd_byte = REVISION;
        default: begin
          if (is_rw(ptr_ff)) begin
            rd_byte = ctrl_ff[3'(ptr_ff - `SCP_OFS_FIRST_RW)];
          end
        end
      endcase
    end else if (block_ff == `SCP_BLOCK_OVERLAY_LOOKUP_TABLE && ptr_ff < OVERLAY_LOOKUP_TABLE_DEPTH) begin
      rd_byte = overlay_lookup_table_mem[ptr_ff][8*lane_ff +: 8];
    end
  end

  // ========================================================================
  // Transmit shifter and open-drain drive
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ff        <= 8'h00;
      drive_low_ff <= 1'b0;
    end else if (bus_evt) begin
      drive_low_ff <= 1'b0;
    end else if (byte_end) begin
      // Ack only a matching address; released for the master's ack in reads
      unique case (state_ff)
        ST_ADDR:                      drive_low_ff <= addr_hit;
        ST_BLOCK, ST_OFFSET, ST_WRITE: drive_low_ff <= 1'b1;
        default:                      drive_low_ff <= 1'b0;
      endcase
    end else if (ack_end) begin
      tx_ff        <= rd_byte;
      drive_low_ff <= rd_load & ~rd_byte[7];
    end else if (scl_fall && state_ff == ST_READ && bit_cnt_ff < `SCP_LAST_DATA_BIT) begin
      tx_ff        <= {tx_ff[6:0], 1'b0};
      drive_low_ff <= ~tx_ff[6];
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~drive_low_ff;

  // ========================================================================
  // Writable control registers; identification offsets have no storage
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `SCP_NUM_RW; i++) begin
        ctrl_ff[i] <= `SCP_RW_RESET;
      end
      upd_tog_ff <= 1'b0;
    end else if (wr_strobe && block_ff == `SCP_BLOCK_CTRL && is_rw(ptr_ff)) begin
      for (int i = 0; i < `SCP_NUM_RW; i++) begin
        if (ptr_ff == 8'(`SCP_OFS_FIRST_RW + i)) begin
          ctrl_ff[i] <= rx_ff & rw_mask(i);
        end
      end
      upd_tog_ff <= ~upd_tog_ff;
    end
  end

  // Overlay table storage, one lane per byte
  always_ff @(posedge link_clk) begin
    if (wr_strobe && block_ff == `SCP_BLOCK_OVERLAY_LOOKUP_TABLE && ptr_ff < OVERLAY_LOOKUP_TABLE_DEPTH) begin
      overlay_lookup_table_mem[ptr_ff][8*lane_ff +: 8] <= rx_ff;
    end
  end

  // ========================================================================
  // Crossing to mclk: the toggle marks new register contents. A write is
  // at least nine bus clocks apart from the next, so the words are stable
  // long before the synchronised toggle arrives.
  logic upd_s, upd_d_ff;

  scp_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_upd_sync (
    .clk   (mclk),
    .rst_n (resetn),
    .d     (upd_tog_ff),
    .q     (upd_s)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      upd_d_ff <= 1'b0;
    end else begin
      upd_d_ff <= upd_s;
    end
  end

  // Captured control outputs; key enables are gated by soft reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      video_run_en          <= 1'b0;
      data_key_enable       <= 1'b0;
      pixel_ramp_mode       <= 2'd0;
      input_format_ctrl     <= `SCP_RW_RESET;
      video_general_ctrl    <= `SCP_RW_RESET;
      ancillary_lock_ctrl   <= `SCP_RW_RESET;
      ancillary_ident_value <= `SCP_RW_RESET;
      keying_overlay_ctrl   <= `SCP_RW_RESET;
      hardware_key_enable   <= 1'b0;
    end else if (upd_s != upd_d_ff) begin
      video_run_en          <= ctrl_ff[0][`SCP_SRST_BIT];
      data_key_enable       <= ctrl_ff[0][`SCP_SRST_BIT] & ctrl_ff[0][`SCP_DATA_KEY_ENABLE_BIT];
      pixel_ramp_mode       <= ctrl_ff[0][`SCP_RAMP_MSB:`SCP_RAMP_LSB];
      input_format_ctrl     <= ctrl_ff[1];
      video_general_ctrl    <= ctrl_ff[2];
      ancillary_lock_ctrl   <= ctrl_ff[3];
      ancillary_ident_value <= ctrl_ff[4];
      keying_overlay_ctrl   <= ctrl_ff[5];
      hardware_key_enable   <= ctrl_ff[0][`SCP_SRST_BIT] & ctrl_ff[5][`SCP_HARDWARE_KEY_ENABLE_BIT];
    end
  end

  // Table read port; output held at zero while in soft reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      overlay_lookup_table_rd_data <= 24'h000000;
    end else if (video_run_en && overlay_lookup_table_rd_addr < OVERLAY_LOOKUP_TABLE_DEPTH) begin
      overlay_lookup_table_rd_data <= overlay_lookup_table_mem[overlay_lookup_table_rd_addr];
    end else begin
      overlay_lookup_table_rd_data <= 24'h000000;
    end
  end

  // ========================================================================
  // Assertions, link domain except a_srst_gates on mclk
  default clocking cb_link @(posedge link_clk); endclocking
  default disable iff (!resetn);

  sequence s_addr_done;
    byte_end && state_ff == ST_ADDR;
  endsequence

  a_addr_ack_given: assert property (s_addr_done ##0 addr_hit |=> drive_low_ff)
    else $error("own address not acknowledged");
  a_addr_foreign: assert property (s_addr_done ##0 !addr_hit
    |=> !drive_low_ff && state_ff == ST_IDLE)
    else $error("foreign address acknowledged");
  a_stop_ends: assert property (stop_det |=> state_ff == ST_IDLE && !drive_low_ff)
    else $error("stop did not end transaction");
  a_restart_addr: assert property (start_det |=> state_ff == ST_ADDR && bit_cnt_ff == 4'hf)
    else $error("repeated start not taken");
  a_nack_release: assert property (ack_end && state_ff == ST_READ && !master_ack_ff
    |=> state_ff == ST_IDLE ##0 !drive_low_ff [*2])
    else $error("read not ended after missing acknowledge");
  a_read_first: assert property (rd_load |=> tx_ff == $past(rd_byte))
    else $error("read byte not from pointer");
  a_ctrl_incr: assert property ((rd_load || wr_strobe) && block_ff == `SCP_BLOCK_CTRL
    && ptr_ff != `SCP_PTR_MAX |=> ptr_ff == 8'($past(ptr_ff) + 8'd1))
    else $error("control pointer did not advance");
  a_lut_triplet: assert property (wr_strobe && block_ff == `SCP_BLOCK_OVERLAY_LOOKUP_TABLE
    && lane_ff != `SCP_OVERLAY_LOOKUP_TABLE_LAST_LANE |=> $stable(ptr_ff) && lane_ff != 2'd0)
    else $error("table location advanced before third byte");
  a_ro_ignored: assert property (wr_strobe && !is_rw(ptr_ff) |=> $stable(upd_tog_ff))
    else $error("identification write took effect");
  a_srst_gates: assert property (@(posedge mclk) disable iff (!resetn)
    !video_run_en |-> !data_key_enable && !hardware_key_enable
    ##1 overlay_lookup_table_rd_data == 24'h000000)
    else $error("outputs active during soft reset");

endmodule // scp_serial_port
`default_nettype wire

// [src/scp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Two-flop synchroniser; the first stage feeds only the second
module scp_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  // Metastability settles in the first stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RESET_VAL;
      q       <= RESET_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // scp_sync
`default_nettype wire

// [testbench/scp_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Two-wire bus master; each SCL quarter is Q mclk cycles, above 4 link periods
module scp_master_model #(
  parameter int Q = 15
) (
  // Clock
  input  wire logic mclk,
  // Bus wires; sda_drv high means released to the pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_q(input int n);
    repeat (n * Q) @(posedge mclk);
  endtask

  // Start and repeated start: SDA falls while SCL high
  task automatic start();
    sda_drv <= 1'b1;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_drv <= 1'b0;
    wait_q(1);
    scl <= 1'b0;
  endtask

  // Stop: SDA rises while SCL high; ends a write
  task automatic stop();
    wait_q(1);
    sda_drv <= 1'b0;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_drv <= 1'b1;
    wait_q(2);
  endtask

  // One bit; SDA only changes while SCL low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic s);
    wait_q(1);
    sda_drv <= b;
    wait_q(1);
    scl <= 1'b1;
    wait_q(2);
    s = sda_line;
    scl <= 1'b0;
  endtask

  // Byte MSB first, then the ninth bit; mack high leaves a read unacknowledged
  task automatic xfer(input logic [7:0] wr, input logic mack,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(wr[i], rd[i]);
    end
    bit_io(mack, ack);
  endtask
endmodule // scp_master_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] PH = 8'h5a; // Arbitrary value
  localparam logic [7:0] PM = 8'h3c; // Arbitrary value
  localparam logic [7:0] PL = 8'hc3; // Arbitrary value
  localparam logic [7:0] RV = 8'h01; // Arbitrary value
  logic        mclk, link_clk, resetn, scl, sda_drv, sda_o, sda_oe_n, sda_line;
  logic        run, dke, hke;
  logic [1:0]  sel, ramp;
  logic [7:0]  oaddr, ifmt, gen, anc, anid, key;
  logic [23:0] odata;
  logic [7:0]  wq[$];
  logic [7:0]  rq[$];
  int          fail_count = 0;
  int          comparisons = 0;

  // Clocks unrelated in phase; line is wired-and with a pull-up
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  initial #3 link_clk = 1'b0;
  always #15 link_clk = ~link_clk;
  assign sda_line = sda_drv & (sda_oe_n | sda_o);

  scp_master_model scp_master_model_inst (.mclk(mclk), .scl(scl), .sda_drv(sda_drv),
                                          .sda_line(sda_line));
  scp_serial_port #(.PART_CODE_HIGH(PH), .PART_CODE_MID(PM), .PART_CODE_LOW(PL),
                    .REVISION(RV)) scp_serial_port_inst (
    .mclk(mclk), .resetn(resetn), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_select_pins(sel), .video_run_en(run),
    .data_key_enable(dke), .pixel_ramp_mode(ramp), .input_format_ctrl(ifmt),
    .video_general_ctrl(gen), .ancillary_lock_ctrl(anc), .ancillary_ident_value(anid),
    .keying_overlay_ctrl(key), .hardware_key_enable(hke), .overlay_lookup_table_rd_addr(oaddr),
    .overlay_lookup_table_rd_data(odata));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Address, block, offset, then the bytes in wq; stop only when asked
  task automatic wr_seq(input logic [7:0] blk, input logic [7:0] ofs, input logic stp);
    logic [7:0] rd;
    logic       a;
    scp_master_model_inst.start();
    scp_master_model_inst.xfer({5'b10101, sel, 1'b0}, 1'b1, rd, a);
    check(a, 0);
    scp_master_model_inst.xfer(blk, 1'b1, rd, a);
    check(a, 0);
    scp_master_model_inst.xfer(ofs, 1'b1, rd, a);
    check(a, 0);
    foreach (wq[i]) begin
      scp_master_model_inst.xfer(wq[i], 1'b1, rd, a);
      check(a, 0);
    end
    if (stp) scp_master_model_inst.stop();
  endtask

  // Read as many bytes as rq holds, last one unacknowledged
  task automatic rd_seq();
    logic [7:0] rd;
    logic       a;
    scp_master_model_inst.start();
    scp_master_model_inst.xfer({5'b10101, sel, 1'b1}, 1'b1, rd, a);
    check(a, 0);
    foreach (rq[i]) begin
      scp_master_model_inst.xfer(8'hff, i == rq.size() - 1, rd, a);
      check(rd, rq[i]);
    end
    repeat (30) @(posedge mclk);
    check(sda_oe_n, 1);
    scp_master_model_inst.stop();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_ident();
    wq = {};
    wr_seq(8'h00, 8'h00, 1'b1);
    rq = {PH, PM, PL, RV};
    rd_seq();
    $display("test ident done");
  endtask

  task automatic t_ctrl();
    wq = {8'h0f, 8'hff, 8'hff, 8'hff, 8'ha5, 8'hff};
    wr_seq(8'h00, 8'h04, 1'b1);
    repeat (10) @(posedge mclk);
    check({run, dke, ramp}, 4'hf);
    check({ifmt, gen, anc}, 24'hbfffe7);
    check({anid, key, 7'h00, hke}, 24'ha5ff01);
    wq = {};
    wr_seq(8'h00, 8'h04, 1'b1);
    rq = {8'h0f, 8'hbf, 8'hff, 8'he7, 8'ha5, 8'hff};
    rd_seq();
    $display("test ctrl done");
  endtask

  // Write to the fixed code, then a repeated start reads it back
  task automatic t_ro();
    wq = {8'hff, 8'h00};
    wr_seq(8'h00, 8'h00, 1'b0);
    // Reload the base with no data so the read starts at offset zero
    wq = {};
    wr_seq(8'h00, 8'h00, 1'b0);
    rq = {PH};
    rd_seq();
    $display("test read only done");
  endtask

  task automatic t_overlay_lookup_table();
    wq = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    wr_seq(8'h01, 8'h10, 1'b1);
    oaddr <= 8'h10;
    repeat (3) @(posedge mclk);
    check(odata, 24'h332211);
    oaddr <= 8'h11;
    repeat (3) @(posedge mclk);
    check(odata[15:0], 16'h5544);
    wq = {8'h00};
    wr_seq(8'h00, 8'h04, 1'b1);
    repeat (10) @(posedge mclk);
    check({run, dke, hke}, 3'h0);
    check(odata, 24'h000000);
    $display("test overlay table done");
  endtask

  task automatic t_addr();
    logic [7:0] rd;
    logic       a;
    scp_master_model_inst.start();
    scp_master_model_inst.xfer({5'b10101, ~sel, 1'b0}, 1'b1, rd, a);
    check(a, 1);
    scp_master_model_inst.stop();
    $display("test address done");
  endtask

  // ==========================================================================
  // Reset, then the sequence; watchdog cuts a hang short
  initial begin
    resetn = 1'b0;
    sel = 2'b10;
    oaddr = 8'h00;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (20) @(posedge mclk);
    t_ident();
    t_ctrl();
    t_ro();
    t_overlay_lookup_table();
    t_addr();
    complete_run();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
